// file: stm_regs.svh
// register offsets, reset values and timing constants of the standard timer
`ifndef STM_REGS_SVH
`define STM_REGS_SVH
`define STM_OFF_CTRL_A      8'h00
`define STM_OFF_CTRL_B      8'h04
`define STM_OFF_CNT_LO      8'h08
`define STM_OFF_CNT_HI      8'h0C
`define STM_OFF_DUTY_LO     8'h10
`define STM_OFF_DUTY_HI     8'h14
`define STM_OFF_FLAGS       8'h18
`define STM_RST_BYTE        8'h00
`define STM_CNT_MAX         10'h3FF
`define STM_PERIOD_COMPARE_SHIFT      7
`define STM_DIV_SYS4        4
`define STM_DIV_H16         16
`define STM_DIV_H64         64
`endif

// file: stm_pkg.sv
// types of the standard timer
package stm_pkg;
    typedef enum logic [1:0] {
        STM_MODE_CMP  = 2'h0,
        STM_MODE_CAP  = 2'h1,
        STM_MODE_PWM  = 2'h2,
        STM_MODE_TMR  = 2'h3
    } stm_mode_t;
    typedef struct packed {
        logic       run_pause;
        logic [2:0] clock_select;
        logic       counter_on;
        logic [2:0] period_compare;
    } stm_ctrl_a_t;
    typedef struct packed {
        stm_mode_t  mode_select;
        logic [1:0] pin_function;
        logic       output_level_ctl;
        logic       output_invert;
        logic       duty_period_swap;
        logic       clear_select;
    } stm_ctrl_b_t;
    typedef struct packed {
        logic        awvalid;
        logic [7:0]  awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [7:0]  araddr;
        logic        rready;
    } stm_axi_req_t;
    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } stm_axi_rsp_t;
    // single pulse tracker states
    typedef enum logic [2:0] {
        STM_PS_IDLE = 3'b001,
        STM_PS_RUN  = 3'b010,
        STM_PS_DONE = 3'b100
    } stm_pulse_t;
endpackage : stm_pkg

// file: stm_timer.sv
// standard timer: axi4-lite registers, 10-bit counter, comparators, output and capture
`timescale 1ns/1ns
`include "stm_regs.svh"
module stm_timer (
    // clock, reset, enable
    input  wire logic           CLOCK_IN,
    input  wire logic           SYS_RST_IN,
    input  wire logic           CLK_EN_IN,
    // internal clock ticks from the oscillator block, one cycle pulses
    input  wire logic           HIGH_TICK_IN,
    input  wire logic           SUB_TICK_IN,
    // pins
    input  wire logic           EXT_CLOCK_PIN_IN,
    input  wire logic           CAPTURE_INPUT_PIN_IN,
    output logic                TIMER_OUTPUT_PIN_OUT,
    // register bus
    input  stm_pkg::stm_axi_req_t AXI_REQ_IN,
    output stm_pkg::stm_axi_rsp_t AXI_RSP_OUT,
    // match flags, level
    output logic                MATCH_A_FLAG_OUT,
    output logic                MATCH_P_FLAG_OUT
);
    import stm_pkg::*;

    stm_ctrl_a_t ctrl_a_reg;
    stm_ctrl_b_t ctrl_b_reg;
    logic [9:0]  duty_reg;
    logic [9:0]  count_reg;
    logic        flag_a_reg;
    logic        flag_p_reg;
    logic        pin_reg;
    logic        on_d_reg;
    logic [5:0]  div_reg;
    logic [5:0]  hdiv_reg;
    logic [2:0]  ext_sync_reg;
    logic [2:0]  cap_sync_reg;
    stm_pulse_t  pulse_reg;

    // bus holding registers
    logic        aw_got_reg;
    logic        w_got_reg;
    logic [7:0]  aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0]  w_strb_reg;
    logic        bvalid_reg;
    logic [1:0]  bresp_reg;
    logic        rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0]  rresp_reg;

    logic        on_rise;
    logic        tick;
    logic        ext_rise;
    logic        ext_fall;
    logic        cap_rise;
    logic        cap_fall;
    logic        cap_hit;
    logic        match_a;
    logic        match_p;
    logic        overflow;
    logic        clear_cnt;
    logic        do_write;
    logic        sp_stop;
    logic [9:0]  period_lim;
    logic [9:0]  duty_lim;
    logic        pwm_active;
    logic        pin_view;
    logic [3:0]  flag_clr;

    // synchronisers: only the later stages feed logic
    always_ff @(posedge CLOCK_IN) begin
        if (SYS_RST_IN) begin
            ext_sync_reg <= 3'h0;
            cap_sync_reg <= 3'h0;
        end else if (CLK_EN_IN) begin
            ext_sync_reg <= {ext_sync_reg[1:0], EXT_CLOCK_PIN_IN};
            cap_sync_reg <= {cap_sync_reg[1:0], CAPTURE_INPUT_PIN_IN};
        end
    end
    assign ext_rise = ext_sync_reg[1] & ~ext_sync_reg[2];
    assign ext_fall = ~ext_sync_reg[1] & ext_sync_reg[2];
    assign cap_rise = cap_sync_reg[1] & ~cap_sync_reg[2];
    assign cap_fall = ~cap_sync_reg[1] & cap_sync_reg[2];

    // prescalers; free running so a source switch needs no restart
    always_ff @(posedge CLOCK_IN) begin
        if (SYS_RST_IN) begin
            div_reg  <= 6'h0;
            hdiv_reg <= 6'h0;
        end else if (CLK_EN_IN) begin
            div_reg <= div_reg + 6'h1;
            if (HIGH_TICK_IN) begin
                hdiv_reg <= hdiv_reg + 6'h1;
            end
        end
    end

    // timer clock source select
    always_comb begin
        case (ctrl_a_reg.clock_select)
            3'h0:    tick = (div_reg[1:0] == 2'(`STM_DIV_SYS4 - 1));
            3'h1:    tick = 1'b1;
            3'h2:    tick = HIGH_TICK_IN && (hdiv_reg[3:0] == 4'(`STM_DIV_H16 - 1));
            3'h3:    tick = HIGH_TICK_IN && (hdiv_reg == 6'(`STM_DIV_H64 - 1));
            3'h4:    tick = SUB_TICK_IN;
            3'h5:    tick = SUB_TICK_IN;
            3'h6:    tick = ext_rise;
            3'h7:    tick = ext_fall;
            default: tick = 1'b0;
        endcase
    end

    // comparators
    assign on_rise    = ctrl_a_reg.counter_on & ~on_d_reg;
    // match on the last count of the period so one period is exactly N*128 ticks
    assign match_p    = (ctrl_a_reg.period_compare != 3'h0) &&
                        (count_reg == period_lim - 10'h1);
    assign overflow   = (count_reg == `STM_CNT_MAX);
    assign match_a    = (duty_reg != 10'h0) && (count_reg == duty_reg);
    assign period_lim = (ctrl_a_reg.period_compare == 3'h0) ? `STM_CNT_MAX :
                        {ctrl_a_reg.period_compare, 7'h0};

    // clear selection per mode
    always_comb begin
        case (ctrl_b_reg.mode_select)
            STM_MODE_PWM: begin
                if (ctrl_b_reg.duty_period_swap) begin
                    clear_cnt = match_a || overflow;
                end else begin
                    clear_cnt = match_p || overflow;
                end
            end
            STM_MODE_CAP: clear_cnt = overflow;
            default: begin
                if (ctrl_b_reg.clear_select) begin
                    clear_cnt = match_a || overflow;
                end else begin
                    clear_cnt = match_p || overflow;
                end
            end
        endcase
    end

    // the counter only ticks while on, not paused
    always_ff @(posedge CLOCK_IN) begin
        if (SYS_RST_IN) begin
            count_reg <= 10'h0;
            on_d_reg  <= 1'b0;
        end else if (CLK_EN_IN) begin
            on_d_reg <= ctrl_a_reg.counter_on;
            if (on_rise) begin
                count_reg <= 10'h0;
            end else if (ctrl_a_reg.counter_on && !ctrl_a_reg.run_pause && tick) begin
                if (clear_cnt && pulse_reg != STM_PS_DONE) begin
                    count_reg <= 10'h0;
                end else begin
                    count_reg <= count_reg + 10'h1;
                end
            end
        end
    end

    // capture edge select
    always_comb begin
        case (ctrl_b_reg.pin_function)
            2'h0:    cap_hit = cap_rise;
            2'h1:    cap_hit = cap_fall;
            2'h2:    cap_hit = cap_rise | cap_fall;
            default: cap_hit = 1'b0;
        endcase
    end

    // a match counts at the tick that leaves the matching value
    logic run_tick;
    logic single_pulse;
    assign run_tick     = ctrl_a_reg.counter_on && !ctrl_a_reg.run_pause && tick && !on_rise;
    assign single_pulse = (ctrl_b_reg.mode_select == STM_MODE_PWM) &&
                          (ctrl_b_reg.pin_function == 2'h3);
    assign sp_stop      = single_pulse && run_tick && match_a;
    assign do_write     = aw_got_reg && w_got_reg && !bvalid_reg;

    // flags: hardware set beats software clear
    always_ff @(posedge CLOCK_IN) begin
        if (SYS_RST_IN) begin
            flag_a_reg <= 1'b0;
            flag_p_reg <= 1'b0;
        end else if (CLK_EN_IN) begin
            if ((run_tick && match_a) ||
                (ctrl_b_reg.mode_select == STM_MODE_CAP && ctrl_a_reg.counter_on && cap_hit)) begin
                flag_a_reg <= 1'b1;
            end else if (flag_clr[0]) begin
                flag_a_reg <= 1'b0;
            end
            if (run_tick && match_p &&
                !(ctrl_b_reg.clear_select && ctrl_b_reg.mode_select != STM_MODE_PWM)) begin
                flag_p_reg <= 1'b1;
            end else if (flag_clr[1]) begin
                flag_p_reg <= 1'b0;
            end
        end
    end
    assign flag_clr = (do_write && aw_addr_reg == `STM_OFF_FLAGS && w_strb_reg[0]) ?
                      w_data_reg[3:0] : 4'h0;

    // control registers; capture and single pulse stop write from hardware
    always_ff @(posedge CLOCK_IN) begin
        if (SYS_RST_IN) begin
            ctrl_a_reg <= stm_ctrl_a_t'(`STM_RST_BYTE);
            ctrl_b_reg <= stm_ctrl_b_t'(`STM_RST_BYTE);
            duty_reg   <= 10'h0;
        end else if (CLK_EN_IN) begin
            if (do_write && w_strb_reg[0]) begin
                case (aw_addr_reg)
                    `STM_OFF_CTRL_A:  ctrl_a_reg     <= stm_ctrl_a_t'(w_data_reg[7:0]);
                    `STM_OFF_CTRL_B:  ctrl_b_reg     <= stm_ctrl_b_t'(w_data_reg[7:0]);
                    `STM_OFF_DUTY_LO: duty_reg[7:0]  <= w_data_reg[7:0];
                    `STM_OFF_DUTY_HI: duty_reg[9:8]  <= w_data_reg[1:0];
                    default: ;
                endcase
            end
            if (sp_stop) begin
                ctrl_a_reg.counter_on <= 1'b0;
            end
            if (ctrl_b_reg.mode_select == STM_MODE_CAP && ctrl_a_reg.counter_on && cap_hit) begin
                duty_reg <= count_reg;
            end
        end
    end

    // pwm duty/period roles
    assign duty_lim   = ctrl_b_reg.duty_period_swap ? period_lim : duty_reg;
    assign pwm_active = (count_reg < duty_lim);

    // single pulse tracker
    always_ff @(posedge CLOCK_IN) begin
        if (SYS_RST_IN) begin
            pulse_reg <= STM_PS_IDLE;
        end else if (CLK_EN_IN) begin
            case (pulse_reg)
                STM_PS_IDLE: if (on_rise) pulse_reg <= STM_PS_RUN;
                STM_PS_RUN:  if (!ctrl_a_reg.counter_on) pulse_reg <= STM_PS_DONE;
                STM_PS_DONE: if (on_rise) pulse_reg <= STM_PS_RUN;
                default:     pulse_reg <= STM_PS_IDLE;
            endcase
        end
    end

    // output pin level before polarity
    always_ff @(posedge CLOCK_IN) begin
        if (SYS_RST_IN) begin
            pin_reg <= 1'b0;
        end else if (CLK_EN_IN) begin
            case (ctrl_b_reg.mode_select)
                STM_MODE_CMP: begin
                    if (on_rise) begin
                        pin_reg <= ctrl_b_reg.output_level_ctl;
                    end else if (run_tick && match_a) begin
                        // equal levels leave the pin unchanged
                        case (ctrl_b_reg.pin_function)
                            2'h1:    pin_reg <= 1'b0;
                            2'h2:    pin_reg <= 1'b1;
                            2'h3:    pin_reg <= ~pin_reg;
                            default: pin_reg <= pin_reg;
                        endcase
                    end
                end
                STM_MODE_PWM: begin
                    case (ctrl_b_reg.pin_function)
                        2'h0:    pin_reg <= ~ctrl_b_reg.output_level_ctl;
                        2'h1:    pin_reg <= ctrl_b_reg.output_level_ctl;
                        2'h2:    pin_reg <= pwm_active ? ctrl_b_reg.output_level_ctl :
                                                        ~ctrl_b_reg.output_level_ctl;
                        default: pin_reg <= (ctrl_a_reg.counter_on && !sp_stop) ?
                                            ctrl_b_reg.output_level_ctl :
                                            ~ctrl_b_reg.output_level_ctl;
                    endcase
                end
                default: pin_reg <= 1'b0;
            endcase
        end
    end
    // timer mode ignores polarity; level there is not to be relied on
    assign pin_view = (ctrl_b_reg.mode_select == STM_MODE_TMR) ? pin_reg :
                      pin_reg ^ ctrl_b_reg.output_invert;
    always_ff @(posedge CLOCK_IN) begin
        if (SYS_RST_IN) begin
            TIMER_OUTPUT_PIN_OUT <= 1'b0;
        end else if (CLK_EN_IN) begin
            TIMER_OUTPUT_PIN_OUT <= pin_view;
        end
    end
    assign MATCH_A_FLAG_OUT = flag_a_reg;
    assign MATCH_P_FLAG_OUT = flag_p_reg;

    // axi write side: address and data taken in either order
    always_ff @(posedge CLOCK_IN) begin
        if (SYS_RST_IN) begin
            aw_got_reg  <= 1'b0;
            w_got_reg   <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_data_reg  <= 32'h0000_0000;
            w_strb_reg  <= 4'h0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= 2'h0;
        end else if (CLK_EN_IN) begin
            if (AXI_REQ_IN.awvalid && !aw_got_reg) begin
                aw_got_reg  <= 1'b1;
                aw_addr_reg <= {AXI_REQ_IN.awaddr[7:2], 2'h0};
            end
            if (AXI_REQ_IN.wvalid && !w_got_reg) begin
                w_got_reg  <= 1'b1;
                w_data_reg <= AXI_REQ_IN.wdata;
                w_strb_reg <= AXI_REQ_IN.wstrb;
            end
            if (do_write) begin
                bvalid_reg <= 1'b1;
                bresp_reg  <= (aw_addr_reg > `STM_OFF_FLAGS ||
                               aw_addr_reg == `STM_OFF_CNT_LO ||
                               aw_addr_reg == `STM_OFF_CNT_HI) ? 2'h2 : 2'h0;
            end else if (bvalid_reg && AXI_REQ_IN.bready) begin
                bvalid_reg <= 1'b0;
                aw_got_reg <= 1'b0;
                w_got_reg  <= 1'b0;
            end
        end
    end

    // axi read side; counter bytes are live
    always_ff @(posedge CLOCK_IN) begin
        if (SYS_RST_IN) begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= 32'h0000_0000;
            rresp_reg  <= 2'h0;
        end else if (CLK_EN_IN) begin
            if (AXI_REQ_IN.arvalid && !rvalid_reg) begin
                rvalid_reg <= 1'b1;
                rresp_reg  <= 2'h0;
                case ({AXI_REQ_IN.araddr[7:2], 2'h0})
                    `STM_OFF_CTRL_A:  rdata_reg <= {24'h0, ctrl_a_reg};
                    `STM_OFF_CTRL_B:  rdata_reg <= {24'h0, ctrl_b_reg};
                    `STM_OFF_CNT_LO:  rdata_reg <= {24'h0, count_reg[7:0]};
                    `STM_OFF_CNT_HI:  rdata_reg <= {30'h0, count_reg[9:8]};
                    `STM_OFF_DUTY_LO: rdata_reg <= {24'h0, duty_reg[7:0]};
                    `STM_OFF_DUTY_HI: rdata_reg <= {30'h0, duty_reg[9:8]};
                    `STM_OFF_FLAGS:   rdata_reg <= {30'h0, flag_p_reg, flag_a_reg};
                    default: begin
                        rdata_reg <= 32'h0000_0000;
                        rresp_reg <= 2'h2;
                    end
                endcase
            end else if (rvalid_reg && AXI_REQ_IN.rready) begin
                rvalid_reg <= 1'b0;
            end
        end
    end

    // handshake outputs
    always_comb begin
        AXI_RSP_OUT         = '0;
        AXI_RSP_OUT.awready = CLK_EN_IN && !aw_got_reg;
        AXI_RSP_OUT.wready  = CLK_EN_IN && !w_got_reg;
        AXI_RSP_OUT.bvalid  = bvalid_reg;
        AXI_RSP_OUT.bresp   = bresp_reg;
        AXI_RSP_OUT.arready = CLK_EN_IN && !rvalid_reg;
        AXI_RSP_OUT.rvalid  = rvalid_reg;
        AXI_RSP_OUT.rdata   = rdata_reg;
        AXI_RSP_OUT.rresp   = rresp_reg;
    end

    // checks
    cnt_on_clear_a: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN)
        (CLK_EN_IN && on_rise) |=> (count_reg == 10'h0))
        else $error("counter not cleared at switch on");
    pause_hold_a: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN)
        (CLK_EN_IN && ctrl_a_reg.run_pause && !on_rise) |=> $stable(count_reg))
        else $error("counter moved while paused");
    off_hold_a: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN)
        (CLK_EN_IN && !ctrl_a_reg.counter_on && on_d_reg == ctrl_a_reg.counter_on)
        |=> $stable(count_reg))
        else $error("counter moved while off");
    step_one_a: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN)
        (CLK_EN_IN && run_tick && !clear_cnt) |=> (count_reg == $past(count_reg) + 10'h1))
        else $error("counter did not step by one");
    p_flag_gate_a: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN)
        (ctrl_b_reg.clear_select && ctrl_b_reg.mode_select == STM_MODE_CMP && !flag_p_reg)
        |=> !flag_p_reg || !$past(ctrl_b_reg.clear_select))
        else $error("period flag set with duty clear");
    zero_duty_a: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN)
        (duty_reg == 10'h0) |-> !match_a)
        else $error("duty match with zero duty");
    init_level_a: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN)
        (CLK_EN_IN && on_rise && ctrl_b_reg.mode_select == STM_MODE_CMP)
        |=> (pin_reg == $past(ctrl_b_reg.output_level_ctl)))
        else $error("pin not at initial level");
    cap_copy_a: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN)
        (CLK_EN_IN && ctrl_b_reg.mode_select == STM_MODE_CAP && ctrl_a_reg.counter_on && cap_hit)
        |=> (duty_reg == $past(count_reg)) && flag_a_reg)
        else $error("capture did not copy counter");
endmodule : stm_timer

// file: stm_timer_tb.sv
// self-checking bench for the standard timer register block
`timescale 1ns/1ns
`include "stm_regs.svh"
module testbench;
    import stm_pkg::*;
    logic         clk;
    logic         rst;
    logic         cap_pin;
    logic         hi_tick;
    logic         sub_tick;
    logic         ext_pin;
    logic         pin_out;
    logic         flag_a;
    logic         flag_p;
    stm_axi_req_t req;
    stm_axi_rsp_t rsp;
    logic [31:0]  rdat;
    logic [1:0]   rres;
    int           err_count;
    int           comparisons;

    // tick and ext clock inputs driven by the bench so every clock source is reachable
    stm_timer dut_u (
        .CLOCK_IN             (clk),
        .SYS_RST_IN           (rst),
        .CLK_EN_IN            (1'b1),
        .HIGH_TICK_IN         (hi_tick),
        .SUB_TICK_IN          (sub_tick),
        .EXT_CLOCK_PIN_IN     (ext_pin),
        .CAPTURE_INPUT_PIN_IN (cap_pin),
        .TIMER_OUTPUT_PIN_OUT (pin_out),
        .AXI_REQ_IN           (req),
        .AXI_RSP_OUT          (rsp),
        .MATCH_A_FLAG_OUT     (flag_a),
        .MATCH_P_FLAG_OUT     (flag_p)
    );

    task automatic finish_test;
        if (err_count == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            $display("wrong value %s expected %h seen %h", nm, e, g);
            err_count++;
        end
    endtask : chk

    // write: each half released once taken, bready kept high throughout
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] e);
        logic aw;
        logic w;
        @(posedge clk);
        aw = 1'b0;
        w = 1'b0;
        req.awaddr <= a;
        req.wdata <= {24'h0, d};
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        while (!(aw && w)) begin
            @(posedge clk);
            if (rsp.awready) aw = 1'b1;
            if (rsp.wready) w = 1'b1;
            req.awvalid <= !aw;
            req.wvalid <= !w;
        end
        do @(posedge clk); while (!rsp.bvalid);
        chk("bresp", {30'h0, e}, {30'h0, rsp.bresp});
    endtask : wr

    // read: rready kept high, data taken at the rvalid edge
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        req.araddr <= a;
        req.arvalid <= 1'b1;
        do @(posedge clk); while (!rsp.arready);
        req.arvalid <= 1'b0;
        do @(posedge clk); while (!rsp.rvalid);
        rdat = rsp.rdata;
        rres = rsp.rresp;
    endtask : rd

    task automatic t_regs;
        for (int i = 0; i < 6; i++) begin
            rd(8'(i * 4));
            chk("reset value", 32'h0, rdat);
        end
        wr(`STM_OFF_DUTY_HI, 8'hFF, 2'h0);
        rd(`STM_OFF_DUTY_HI);
        chk("duty_hi", 32'h3, rdat);
        wr(`STM_OFF_CNT_LO, 8'h55, 2'h2);
        rd(8'h1C);
        chk("rresp", 32'h2, {30'h0, rres});
        wr(`STM_OFF_DUTY_HI, 8'h00, 2'h0);
    endtask : t_regs

    task automatic t_pause;
        logic [31:0] v;
        wr(`STM_OFF_CTRL_B, 8'hC0, 2'h0);
        wr(`STM_OFF_CTRL_A, 8'h18, 2'h0);
        repeat (20) @(posedge clk);
        wr(`STM_OFF_CTRL_A, 8'h98, 2'h0);
        rd(`STM_OFF_CNT_LO);
        v = rdat;
        rd(`STM_OFF_CNT_LO);
        chk("paused", v, rdat);
        wr(`STM_OFF_CTRL_A, 8'h18, 2'h0);
        rd(`STM_OFF_CNT_LO);
        chk("resumed", 32'h1, {31'h0, rdat > v});
        wr(`STM_OFF_CTRL_A, 8'h10, 2'h0);
        rd(`STM_OFF_CNT_LO);
        v = rdat;
        rd(`STM_OFF_CNT_LO);
        chk("off keeps", v, rdat);
        wr(`STM_OFF_CTRL_A, 8'h18, 2'h0);
        rd(`STM_OFF_CNT_LO);
        chk("on clears", 32'h1, {31'h0, rdat < v});
    endtask : t_pause

    task automatic t_cmp;
        wr(`STM_OFF_CTRL_A, 8'h00, 2'h0);
        wr(`STM_OFF_DUTY_LO, 8'h81, 2'h0);
        wr(`STM_OFF_CTRL_B, 8'h21, 2'h0);
        wr(`STM_OFF_FLAGS, 8'h03, 2'h0);
        // period below duty: the period comparator matches but must not flag
        wr(`STM_OFF_CTRL_A, 8'h19, 2'h0);
        repeat (150) @(posedge clk);
        chk("flag_a", 32'h1, {31'h0, flag_a});
        chk("flag_p", 32'h0, {31'h0, flag_p});
        chk("pin high", 32'h1, {31'h0, pin_out});
        rd(`STM_OFF_CNT_LO);
        chk("cleared", 32'h1, {31'h0, rdat < 32'h82});
        wr(`STM_OFF_CTRL_A, 8'h00, 2'h0);
        wr(`STM_OFF_CTRL_A, 8'h19, 2'h0);
        repeat (3) @(posedge clk);
        chk("pin initial", 32'h0, {31'h0, pin_out});
        wr(`STM_OFF_CTRL_A, 8'h00, 2'h0);
    endtask : t_cmp

    task automatic t_cap;
        wr(`STM_OFF_CTRL_B, 8'h40, 2'h0);
        wr(`STM_OFF_FLAGS, 8'h03, 2'h0);
        chk("flag cleared", 32'h0, {31'h0, flag_a});
        wr(`STM_OFF_CTRL_A, 8'h18, 2'h0);
        repeat (30) @(posedge clk);
        cap_pin <= 1'b1;
        repeat (8) @(posedge clk);
        chk("capture flag", 32'h1, {31'h0, flag_a});
        rd(`STM_OFF_DUTY_LO);
        chk("captured", 32'h1, {31'h0, rdat > 20});
    endtask : t_cap

    task automatic t_clk;
        wr(`STM_OFF_CTRL_A, 8'h00, 2'h0);
        wr(`STM_OFF_CTRL_A, 8'h68, 2'h0);
        repeat (5) begin
            ext_pin <= 1'b1;
            repeat (4) @(posedge clk);
            ext_pin <= 1'b0;
            repeat (4) @(posedge clk);
        end
        rd(`STM_OFF_CNT_LO);
        chk("ext rise count", 32'h5, rdat);
        wr(`STM_OFF_CTRL_A, 8'h00, 2'h0);
        wr(`STM_OFF_CTRL_A, 8'h78, 2'h0);
        repeat (3) begin
            ext_pin <= 1'b1;
            repeat (4) @(posedge clk);
            ext_pin <= 1'b0;
            repeat (4) @(posedge clk);
        end
        rd(`STM_OFF_CNT_LO);
        chk("ext fall count", 32'h3, rdat);
        wr(`STM_OFF_CTRL_A, 8'h00, 2'h0);
        wr(`STM_OFF_CTRL_A, 8'h48, 2'h0);
        repeat (6) begin
            sub_tick <= 1'b1;
            @(posedge clk);
            sub_tick <= 1'b0;
            repeat (2) @(posedge clk);
        end
        rd(`STM_OFF_CNT_LO);
        chk("sub count", 32'h6, rdat);
        wr(`STM_OFF_CTRL_A, 8'h00, 2'h0);
        wr(`STM_OFF_CTRL_A, 8'h28, 2'h0);
        repeat (32) begin
            hi_tick <= 1'b1;
            @(posedge clk);
            hi_tick <= 1'b0;
            @(posedge clk);
        end
        rd(`STM_OFF_CNT_LO);
        chk("high/16 count", 32'h2, rdat);
    endtask : t_clk

    // pwm: period 128, duty 32; high count over two periods, plain and inverted
    task automatic t_pwm;
        int hi;
        wr(`STM_OFF_CTRL_A, 8'h00, 2'h0);
        wr(`STM_OFF_DUTY_LO, 8'h20, 2'h0);
        wr(`STM_OFF_DUTY_HI, 8'h00, 2'h0);
        for (int k = 0; k < 2; k++) begin
            wr(`STM_OFF_CTRL_B, 8'hA8 | 8'(k * 4), 2'h0);
            wr(`STM_OFF_CTRL_A, 8'h19, 2'h0);
            repeat (20) @(posedge clk);
            hi = 0;
            repeat (256) begin
                @(posedge clk);
                hi += int'(pin_out);
            end
            chk("pwm high count", (k == 0) ? 32'h40 : 32'hC0, 32'(hi));
            wr(`STM_OFF_CTRL_A, 8'h00, 2'h0);
        end
        wr(`STM_OFF_CTRL_B, 8'h98, 2'h0);
        repeat (3) @(posedge clk);
        chk("forced active", 32'h1, {31'h0, pin_out});
    endtask : t_pwm

    // 4 ns clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // hang guard, far beyond the thousand or so cycles the tests need
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        finish_test();
    end

    initial begin
        rst = 1'b1;
        cap_pin = 1'b0;
        hi_tick = 1'b0;
        sub_tick = 1'b0;
        ext_pin = 1'b0;
        req = '0;
        req.wstrb = 4'hF;
        req.bready = 1'b1;
        req.rready = 1'b1;
        err_count = 0;
        comparisons = 0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_pause();
        t_cmp();
        t_cap();
        t_clk();
        t_pwm();
        finish_test();
    end
endmodule : testbench
